/* verilog/msg_queue_unit.sv */
// Message queue unit: queue ports, pointer registers and local memory
// sequencer, plus the posted-write buffer that feeds the sequencer.
// Assumes every port, including the memory port, runs on sys_clk_i.
//
// Contract
// - enabled unit reports class code 0E/00/01
// - four regions laid out consecutively from base
// - inbound port read fetches free tail, increments
// - empty free list reads all ones, no advance
// - inbound port write stores at post head
// - inbound post sets status, interrupts unless masked
// - outbound port write stores at free head
// - outbound pending while head differs from tail
// - mask gates remote interrupt, not status
// - outbound port read fetches post tail, increments
// - empty outbound post list reads all ones
// - remote and local register windows kept apart
// - outbound pending is status bit five, read-only
`timescale 1ns/1ns

// ----------------------------------------------------------------------
// Posted-write buffer.
// ----------------------------------------------------------------------
module msg_queue_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // Depth must be a power of two so the pointers wrap by themselves.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("msg_queue_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH]; // Entry storage.
  logic [AW:0] wr_q; // Write pointer with wrap bit.
  logic [AW:0] rd_q; // Read pointer with wrap bit.
  wire logic full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire logic empty = (wr_q == rd_q);
  wire logic push = in_valid_i && !full;
  wire logic pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_q[AW-1:0]];

  // Pointers advance on each accepted push or pop.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end

  // Storage has no reset; an entry is only read after it is written.
  always_ff @(posedge sys_clk_i) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data_i;
  end
endmodule : msg_queue_fifo

// ----------------------------------------------------------------------
// Queue unit top.
// ----------------------------------------------------------------------
module msg_queue_unit #(
  parameter int BUF_DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Remote register port: request held until the one-cycle ack.
  input wire logic pci_req_i,
  input wire logic pci_we_i,
  input wire logic [11:0] pci_addr_i,
  input wire logic [31:0] pci_wdata_i,
  output logic pci_ack_o,
  output logic [31:0] pci_rdata_o,
  // Class code seen by configuration reads at bytes 0x09..0x0B.
  output logic [23:0] cfg_class_code_o,
  // Local register port, same handshake.
  input wire logic loc_req_i,
  input wire logic loc_we_i,
  input wire logic [19:0] loc_addr_i,
  input wire logic [31:0] loc_wdata_i,
  output logic loc_ack_o,
  output logic [31:0] loc_rdata_o,
  // Local memory master port: request held until ack.
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Interrupts.
  output logic inta_b_o,
  output logic local_irq_o
);
  // Class code shown while the unit is disabled; value is arbitrary.
  localparam logic [23:0] IDLE_CLASS_CODE = 24'h00_0000;

  if (BUF_DEPTH < 2) begin : g_bad_buf
    $error("msg_queue_unit: BUF_DEPTH must be at least 2");
  end

  // --------------------------------------------------------------------
  // State.
  // --------------------------------------------------------------------
  msg_queue_pkg::mem_state_t state_q; // Memory sequencer state.
  logic [31:0] ptr_q [0:7]; // Head and tail pointers.
  logic [31:0] ctrl_q; // Enable and FIFO size code.
  logic [31:0] base_q; // Queue base address.
  logic [31:0] out_mask_q; // Remote interrupt mask.
  logic [31:0] in_mask_q; // Local interrupt mask.
  logic in_post_pending_q; // Sticky inbound post flag.
  logic pci_ack_q; // Remote ack pulse.
  logic [31:0] pci_rdata_q; // Remote read data.
  logic loc_ack_q; // Local ack pulse.
  logic [31:0] loc_rdata_q; // Local read data.
  logic rd_in_q; // Current fetch serves the inbound port.
  logic wr_in_q; // Current store serves the inbound port.
  logic [31:0] mem_addr_q; // Memory address.
  logic [31:0] mem_wdata_q; // Memory write data.
  logic [23:0] class_q; // Class code register.
  logic inta_b_q; // Remote interrupt, active low.
  logic local_irq_q; // Local interrupt.

  // --------------------------------------------------------------------
  // Region geometry.
  // --------------------------------------------------------------------
  wire logic [2:0] size_code_raw = ctrl_q[msg_queue_pkg::CTRL_SIZE_LSB +: 3];
  // Codes past the largest size behave as the largest.
  wire logic [2:0] size_code = (size_code_raw > msg_queue_pkg::CTRL_SIZE_MAX)
    ? msg_queue_pkg::CTRL_SIZE_MAX : size_code_raw;
  wire logic [31:0] fifo_size = msg_queue_pkg::FIFO_SIZE_UNIT << size_code;
  wire logic [31:0] base_value = base_q & msg_queue_pkg::BASE_ALIGN_MASK;
  wire logic unit_enable = ctrl_q[msg_queue_pkg::CTRL_ENABLE_BIT];

  // --------------------------------------------------------------------
  // Queue conditions.
  // --------------------------------------------------------------------
  wire logic in_free_empty = ptr_q[msg_queue_pkg::IN_FREE_HEAD] ==
    ptr_q[msg_queue_pkg::IN_FREE_TAIL];
  wire logic out_post_pending = ptr_q[msg_queue_pkg::OUT_POST_HEAD] !=
    ptr_q[msg_queue_pkg::OUT_POST_TAIL];

  // --------------------------------------------------------------------
  // Remote decode.
  // --------------------------------------------------------------------
  wire logic pci_live = pci_req_i && !pci_ack_q;
  wire logic pci_is_status = pci_addr_i == msg_queue_pkg::PCI_OUT_STATUS;
  wire logic pci_is_mask = pci_addr_i == msg_queue_pkg::PCI_OUT_MASK;
  wire logic pci_is_in = pci_addr_i == msg_queue_pkg::PCI_IN_PORT;
  wire logic pci_is_out = pci_addr_i == msg_queue_pkg::PCI_OUT_PORT;
  wire logic pci_is_port = pci_is_in || pci_is_out;
  wire logic pci_plain = pci_live && !pci_is_port;
  wire logic port_wr = pci_live && pci_we_i && pci_is_port;
  wire logic port_rd = pci_live && !pci_we_i && pci_is_port;
  wire logic seq_idle = state_q == msg_queue_pkg::ST_IDLE;
  wire logic src_empty = pci_is_in ? in_free_empty : !out_post_pending;
  wire logic rd_empty_ans = port_rd && seq_idle && src_empty;
  wire logic rd_start = port_rd && seq_idle && !src_empty;
  wire logic rd_done = (state_q == msg_queue_pkg::ST_READ) && mem_ack_i;
  wire logic wr_done = (state_q == msg_queue_pkg::ST_WRITE) && mem_ack_i;
  // Bit five alone reflects the outbound post queue here.
  wire logic [31:0] out_status = {26'h0, out_post_pending, 5'h00};

  // --------------------------------------------------------------------
  // Posted-write buffer: port writes queue up, so a slow memory stalls
  // the remote ack instead of losing a frame pointer.
  // --------------------------------------------------------------------
  wire logic buf_in_ready;
  wire logic buf_out_valid;
  wire logic [32:0] buf_out_data;
  wire logic buf_pop = seq_idle && !rd_start;
  msg_queue_fifo #(.WIDTH(33), .DEPTH(BUF_DEPTH)) u_buf (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .in_valid_i(port_wr),
    .in_ready_o(buf_in_ready),
    .in_data_i({pci_is_in, pci_wdata_i}),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );
  wire logic wr_start = buf_pop && buf_out_valid;

  // --------------------------------------------------------------------
  // Local decode.
  // --------------------------------------------------------------------
  wire logic loc_live = loc_req_i && !loc_ack_q;
  wire logic loc_wr = loc_live && loc_we_i;
  wire logic loc_rd = loc_live && !loc_we_i;
  wire logic loc_is_in_status = loc_addr_i == msg_queue_pkg::LOC_IN_STATUS;
  wire logic loc_is_in_mask = loc_addr_i == msg_queue_pkg::LOC_IN_MASK;
  wire logic loc_is_ctrl = loc_addr_i == msg_queue_pkg::LOC_CONTROL;
  wire logic loc_is_base = loc_addr_i == msg_queue_pkg::LOC_BASE;
  wire logic in_post_set = wr_done && wr_in_q;
  wire logic in_post_clr = loc_wr && loc_is_in_status &&
    loc_wdata_i[msg_queue_pkg::POST_PENDING_BIT];

  // --------------------------------------------------------------------
  // Pointer registers, one per entry. Hardware steps win over a local
  // write in the same cycle so an automatic advance is never lost.
  // --------------------------------------------------------------------
  logic [7:0] ptr_inc;
  logic [31:0] loc_ptr_rd [0:7];
  assign ptr_inc[msg_queue_pkg::IN_FREE_TAIL] = rd_done && rd_in_q;
  assign ptr_inc[msg_queue_pkg::OUT_POST_TAIL] = rd_done && !rd_in_q;
  assign ptr_inc[msg_queue_pkg::IN_POST_HEAD] = wr_done && wr_in_q;
  assign ptr_inc[msg_queue_pkg::OUT_FREE_HEAD] = wr_done && !wr_in_q;
  assign ptr_inc[msg_queue_pkg::IN_POST_TAIL] = 1'b0;
  assign ptr_inc[msg_queue_pkg::OUT_POST_HEAD] = 1'b0;
  assign ptr_inc[msg_queue_pkg::IN_FREE_HEAD] = 1'b0;
  assign ptr_inc[msg_queue_pkg::OUT_FREE_TAIL] = 1'b0;

  for (genvar i = 0; i < 8; i++) begin : g_ptr
    // region start from base and slot
    wire logic [31:0] slot = {30'h0, msg_queue_pkg::PTR_REGION[i]};
    wire logic [31:0] start = base_value + 32'(fifo_size * slot);
    wire logic [31:0] step = ptr_q[i] + msg_queue_pkg::ENTRY_BYTES;
    // one word step, wrap at region end
    wire logic [31:0] next = (step == start + fifo_size) ? start : step;
    wire logic hit = loc_addr_i == msg_queue_pkg::LOC_PTR[i];
    assign loc_ptr_rd[i] = hit ? ptr_q[i] : 32'h0000_0000;
    always_ff @(posedge sys_clk_i) begin
      if (!rst_b_i) ptr_q[i] <= 32'h0000_0000;
      else if (ptr_inc[i]) ptr_q[i] <= next;
      else if (loc_wr && hit) ptr_q[i] <= loc_wdata_i;
    end
  end

  // --------------------------------------------------------------------
  // Memory sequencer: a pending port read goes first, then the buffer.
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_q <= msg_queue_pkg::ST_IDLE;
      rd_in_q <= 1'b0;
      wr_in_q <= 1'b0;
      mem_addr_q <= 32'h0000_0000;
      mem_wdata_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        msg_queue_pkg::ST_IDLE: begin
          if (rd_start) begin
            state_q <= msg_queue_pkg::ST_READ;
            rd_in_q <= pci_is_in;
            mem_addr_q <= pci_is_in ? ptr_q[msg_queue_pkg::IN_FREE_TAIL]
              : ptr_q[msg_queue_pkg::OUT_POST_TAIL];
          end else if (wr_start) begin
            state_q <= msg_queue_pkg::ST_WRITE;
            wr_in_q <= buf_out_data[32];
            mem_wdata_q <= buf_out_data[31:0];
            mem_addr_q <= buf_out_data[32]
              ? ptr_q[msg_queue_pkg::IN_POST_HEAD]
              : ptr_q[msg_queue_pkg::OUT_FREE_HEAD];
          end
        end
        msg_queue_pkg::ST_READ, msg_queue_pkg::ST_WRITE: begin
          if (mem_ack_i) state_q <= msg_queue_pkg::ST_IDLE;
        end
        default: state_q <= msg_queue_pkg::ST_IDLE;
      endcase
    end
  end

  assign mem_req_o = !seq_idle;
  assign mem_we_o = state_q == msg_queue_pkg::ST_WRITE;
  assign mem_addr_o = mem_addr_q;
  assign mem_wdata_o = mem_wdata_q;

  // --------------------------------------------------------------------
  // Remote register side.
  // --------------------------------------------------------------------
  wire logic pci_ack_d = pci_plain || (port_wr && buf_in_ready) ||
    rd_empty_ans || rd_done;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pci_ack_q <= 1'b0;
      pci_rdata_q <= 32'h0000_0000;
    end else begin
      pci_ack_q <= pci_ack_d;
      // all ones when free list empty
      // all ones when post list empty
      if (rd_empty_ans) pci_rdata_q <= msg_queue_pkg::EMPTY_FRAME;
      else if (rd_done) pci_rdata_q <= mem_rdata_i;
      else if (pci_plain && !pci_we_i)
        pci_rdata_q <= pci_is_status ? out_status
          : (pci_is_mask ? out_mask_q : 32'h0000_0000);
    end
  end

  // Remote mask writes; only defined mask bits are kept.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) out_mask_q <= 32'h0000_0000;
    else if (pci_plain && pci_we_i && pci_is_mask)
      out_mask_q <= pci_wdata_i & msg_queue_pkg::OUT_MASK_WRITABLE;
  end

  assign pci_ack_o = pci_ack_q;
  assign pci_rdata_o = pci_rdata_q;

  // --------------------------------------------------------------------
  // Local register side.
  // --------------------------------------------------------------------
  logic [31:0] loc_rd_mux;
  always_comb begin
    loc_rd_mux = 32'h0000_0000;
    for (int i = 0; i < 8; i++) loc_rd_mux = loc_rd_mux | loc_ptr_rd[i];
    if (loc_is_in_status)
      loc_rd_mux = {26'h0, in_post_pending_q, 5'h00};
    if (loc_is_in_mask) loc_rd_mux = in_mask_q;
    if (loc_is_ctrl) loc_rd_mux = ctrl_q;
    if (loc_is_base) loc_rd_mux = base_q;
  end

  // Local control registers and the ack pulse.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      loc_ack_q <= 1'b0;
      loc_rdata_q <= 32'h0000_0000;
      in_mask_q <= 32'h0000_0000;
      ctrl_q <= 32'h0000_0000;
      base_q <= 32'h0000_0000;
    end else begin
      loc_ack_q <= loc_live;
      if (loc_rd) loc_rdata_q <= loc_rd_mux;
      if (loc_wr && loc_is_in_mask)
        in_mask_q <= loc_wdata_i & msg_queue_pkg::IN_MASK_WRITABLE;
      if (loc_wr && loc_is_ctrl)
        ctrl_q <= loc_wdata_i & msg_queue_pkg::CTRL_WRITABLE;
      // low bits dropped; alignment is software's
      if (loc_wr && loc_is_base)
        base_q <= loc_wdata_i & msg_queue_pkg::BASE_ALIGN_MASK;
    end
  end

  assign loc_ack_o = loc_ack_q;
  assign loc_rdata_o = loc_rdata_q;

  // --------------------------------------------------------------------
  // Status, interrupts and identification.
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      in_post_pending_q <= 1'b0;
      inta_b_q <= 1'b1;
      local_irq_q <= 1'b0;
      class_q <= IDLE_CLASS_CODE;
    end else begin
      // post sets flag; set beats clear
      if (in_post_set) in_post_pending_q <= 1'b1;
      else if (in_post_clr) in_post_pending_q <= 1'b0;
      local_irq_q <= in_post_pending_q &&
        !in_mask_q[msg_queue_pkg::POST_PENDING_BIT];
      // mask gates only the remote line
      inta_b_q <= !(out_post_pending &&
        !out_mask_q[msg_queue_pkg::POST_PENDING_BIT]);
      class_q <= unit_enable ? msg_queue_pkg::QUEUE_CLASS_CODE
        : IDLE_CLASS_CODE;
    end
  end

  assign inta_b_o = inta_b_q;
  assign local_irq_o = local_irq_q;
  assign cfg_class_code_o = class_q;

  // --------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------
  AST_CLASS_CODE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    unit_enable |=> cfg_class_code_o == msg_queue_pkg::QUEUE_CLASS_CODE)
    else $error("class code wrong while enabled");

  AST_IN_FETCH_ADDR: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    rd_start && pci_is_in |=>
      mem_req_o && !mem_we_o &&
      mem_addr_o == $past(ptr_q[msg_queue_pkg::IN_FREE_TAIL]))
    else $error("inbound fetch not at free tail");

  AST_EMPTY_ONES: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    rd_empty_ans |=> pci_ack_o &&
      pci_rdata_o == msg_queue_pkg::EMPTY_FRAME && !mem_req_o)
    else $error("empty queue read did not return all ones");

  AST_EMPTY_HOLD: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    rd_empty_ans && pci_is_in && !loc_wr |=>
      $stable(ptr_q[msg_queue_pkg::IN_FREE_TAIL]))
    else $error("free tail moved on empty read");

  AST_POST_FLAG: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    in_post_set && !in_mask_q[msg_queue_pkg::POST_PENDING_BIT] |=>
      in_post_pending_q ##1 local_irq_o)
    else $error("inbound post did not raise flag and interrupt");

  AST_FREE_STORE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    wr_start && !buf_out_data[32] |=>
      mem_we_o &&
      mem_addr_o == $past(ptr_q[msg_queue_pkg::OUT_FREE_HEAD]))
    else $error("outbound return not stored at free head");

  AST_OUT_IRQ: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    out_post_pending && !out_mask_q[msg_queue_pkg::POST_PENDING_BIT] |=>
      !inta_b_o)
    else $error("remote interrupt missing while posts pending");

  AST_OUT_MASKED: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    out_mask_q[msg_queue_pkg::POST_PENDING_BIT] |=> inta_b_o)
    else $error("masked remote interrupt asserted");

  AST_TAIL_STEP: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    rd_done && !rd_in_q |=> ptr_q[msg_queue_pkg::OUT_POST_TAIL] !=
      $past(ptr_q[msg_queue_pkg::OUT_POST_TAIL]))
    else $error("outbound post tail did not advance");

  AST_WRAP: assert property (
    @(posedge sys_clk_i) disable iff (!rst_b_i)
    ptr_inc[msg_queue_pkg::IN_POST_HEAD] && !loc_wr |=>
      ptr_q[msg_queue_pkg::IN_POST_HEAD] ==
      (($past(ptr_q[msg_queue_pkg::IN_POST_HEAD]) == base_value +
        (fifo_size << 1) - msg_queue_pkg::ENTRY_BYTES)
      ? base_value + fifo_size
      : $past(ptr_q[msg_queue_pkg::IN_POST_HEAD]) +
        msg_queue_pkg::ENTRY_BYTES))
    else $error("inbound post head step or wrap wrong");

endmodule : msg_queue_unit

/* include/msg_queue_pkg.sv */
// Constants used by the message queue unit top; its data buffer uses none of them.
// Assumes a 32-bit local memory and 32-bit register ports on one clock.
package msg_queue_pkg;

  // ------------------------------------------------------------------
  // Remote (PCI side) register offsets.
  // ------------------------------------------------------------------
  localparam logic [11:0] PCI_OUT_STATUS = 12'h030;
  localparam logic [11:0] PCI_OUT_MASK = 12'h034;
  localparam logic [11:0] PCI_IN_PORT = 12'h040;
  localparam logic [11:0] PCI_OUT_PORT = 12'h044;

  // ------------------------------------------------------------------
  // Local register offsets.
  // ------------------------------------------------------------------
  localparam logic [19:0] LOC_IN_STATUS = 20'h00100;
  localparam logic [19:0] LOC_IN_MASK = 20'h00104;
  localparam logic [19:0] LOC_CONTROL = 20'h00164;
  localparam logic [19:0] LOC_BASE = 20'h00170;
  // Pointer offsets, in pointer index order below.
  localparam logic [19:0] LOC_PTR [0:7] = '{20'h00120, 20'h00128,
    20'h00130, 20'h00138, 20'h00140, 20'h00148, 20'h00150, 20'h00158};

  // Pointer indices into the pointer array.
  localparam int IN_FREE_HEAD = 0;
  localparam int IN_FREE_TAIL = 1;
  localparam int IN_POST_HEAD = 2;
  localparam int IN_POST_TAIL = 3;
  localparam int OUT_FREE_HEAD = 4;
  localparam int OUT_FREE_TAIL = 5;
  localparam int OUT_POST_HEAD = 6;
  localparam int OUT_POST_TAIL = 7;
  // Region slot of each pointer counted in FIFO sizes from the base.
  localparam logic [1:0] PTR_REGION [0:7] = '{2'h0, 2'h0, 2'h1, 2'h1,
    2'h3, 2'h3, 2'h2, 2'h2};

  // ------------------------------------------------------------------
  // Field layouts and values.
  // ------------------------------------------------------------------
  localparam int POST_PENDING_BIT = 5;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_SIZE_LSB = 1;
  localparam logic [2:0] CTRL_SIZE_MAX = 3'h4;
  localparam logic [31:0] OUT_MASK_WRITABLE = 32'h0000_002B;
  localparam logic [31:0] IN_MASK_WRITABLE = 32'h0000_0020;
  localparam logic [31:0] CTRL_WRITABLE = 32'h0000_000F;
  localparam logic [31:0] BASE_ALIGN_MASK = 32'hFFF0_0000;
  localparam logic [31:0] FIFO_SIZE_UNIT = 32'h0000_1000;
  localparam logic [31:0] ENTRY_BYTES = 32'h0000_0004;
  localparam logic [31:0] EMPTY_FRAME = 32'hFFFF_FFFF;
  localparam logic [23:0] QUEUE_CLASS_CODE = 24'h0E_0001;

  // Memory sequencer states.
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} mem_state_t;

endpackage : msg_queue_pkg

/* dv/msg_mem_model.sv */
// Local memory model that answers the unit's memory master port.
// Assumes one access at a time inside a 16 KB window.
`timescale 1ns/1ns
module msg_mem_model (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [31:0] addr_i,
  input wire logic [31:0] wdata_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  // Word store; the bench preloads frame pointers here.
  logic [31:0] mem [0:4095];
  // A new access is one that is not yet being acknowledged.
  wire take = req_i && !ack_o;
  // one-cycle answer.
  // Read data is inverted outside an answer so stale data cannot pass.
  always_ff @(posedge sys_clk_i) begin
    ack_o <= rst_b_i && take;
    if (take && we_i) mem[addr_i[13:2]] <= wdata_i;
    rdata_o <= take ? mem[addr_i[13:2]] : ~rdata_o;
  end
endmodule : msg_mem_model

/* dv/msg_queue_unit_tb.sv */
// Self-checking bench for the message queue unit.
// Assumes queue base 0x0010_0000 and the smallest FIFO size, 4 KB.
`timescale 1ns/1ns
module msg_queue_unit_tb;
  logic clk = 0, rst_b = 0, pr = 0, pw = 0, lr = 0, lw = 0;
  logic [11:0] pa = 0;
  logic [19:0] la = 0;
  logic [31:0] pd = 0, ld = 0, prd, lrd, maddr, mwd, mrd, r;
  logic pack, lack, mreq, mwe, mack, inta_b, lirq;
  logic [23:0] cls;
  int n_fail = 0, tests_run = 0, k;
  // Rows: local offset, value written, value read back.
  // base on a 1 Mbyte boundary.
  // core posts one frame, steps head.
  logic [83:0] rows [12] = '{{20'h00164, 32'h1, 32'h1},
    {20'h00170, 32'h0010_0000, 32'h0010_0000},
    {20'h00104, 32'hFFFF_FFFF, 32'h20}, {20'h00104, 32'h0, 32'h0},
    {20'h00200, 32'h5, 32'h0}, {20'h00120, 32'h0010_0004, 32'h0010_0004},
    {20'h00128, 32'h0010_0000, 32'h0010_0000},
    {20'h00130, 32'h0010_1000, 32'h0010_1000},
    {20'h00150, 32'h0010_2004, 32'h0010_2004},
    {20'h00158, 32'h0010_2000, 32'h0010_2000},
    {20'h00140, 32'h0010_3000, 32'h0010_3000},
    {20'h00148, 32'h0010_3000, 32'h0010_3000}};
  msg_queue_unit #(.BUF_DEPTH(16)) msg_queue_unit_inst (.sys_clk_i(clk),
    .rst_b_i(rst_b), .pci_req_i(pr), .pci_we_i(pw), .pci_addr_i(pa),
    .pci_wdata_i(pd), .pci_ack_o(pack), .pci_rdata_o(prd),
    .cfg_class_code_o(cls), .loc_req_i(lr), .loc_we_i(lw), .loc_addr_i(la),
    .loc_wdata_i(ld), .loc_ack_o(lack), .loc_rdata_o(lrd), .mem_req_o(mreq),
    .mem_we_o(mwe), .mem_addr_o(maddr), .mem_wdata_o(mwd), .mem_ack_i(mack),
    .mem_rdata_i(mrd), .inta_b_o(inta_b), .local_irq_o(lirq));
  msg_mem_model msg_mem_model_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
    .req_i(mreq), .we_i(mwe), .addr_i(maddr), .wdata_i(mwd), .ack_o(mack),
    .rdata_o(mrd));
  initial forever #4 clk = ~clk;
  task automatic wrap_up();
    if (n_fail == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Request held until ack is sampled high at a rising edge; the answer
  // is taken at that edge and the request dropped there. A missing ack
  // counts as a mismatch so a stalled port cannot pass silently.
  task automatic acc(input bit p, input bit we, input logic [19:0] a,
    input logic [31:0] d);
    @(posedge clk);
    {pr, pw, pa, pd} <= {p, we, a[11:0], d};
    {lr, lw, la, ld} <= {!p, we, a, d};
    @(posedge clk);
    for (k = 0; k < 50 && (p ? pack : lack) !== 1'b1; k++) @(posedge clk);
    if (k == 50) begin
      n_fail++;
      $display("[FAIL] %0t no ack", $time);
    end
    r = p ? prd : lrd;
    pr <= 1'b0;
    lr <= 1'b0;
  endtask : acc
  task automatic rd(input bit p, input logic [19:0] a, input logic [31:0] e);
    acc(p, 1'b0, a, 32'h0);
    chk(r, e);
  endtask : rd
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
  initial begin
    msg_mem_model_inst.mem[0] = 32'h0000_8000;
    msg_mem_model_inst.mem[12'h800] = 32'h0000_9040;
    repeat (16) @(posedge clk);
    chk({7'h0, inta_b, cls}, 32'h0100_0000);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      acc(0, 1, rows[i][83:64], rows[i][63:32]);
      rd(0, rows[i][83:64], rows[i][31:0]);
    end
    chk({8'h0, cls}, 32'h000E_0001);
    rd(1, 20'h040, 32'h0000_8000);
    rd(0, 20'h00128, 32'h0010_0004);
    rd(1, 20'h040, 32'hFFFF_FFFF);
    acc(1, 1, 20'h040, 32'h0000_A000);
    for (k = 0; k < 20 && lirq !== 1'b1; k++) @(negedge clk);
    chk(msg_mem_model_inst.mem[12'h400], 32'h0000_A000);
    chk({31'h0, lirq}, 32'h1);
    rd(0, 20'h00100, 32'h20);
    rd(0, 20'h00130, 32'h0010_1004);
    chk({31'h0, inta_b}, 32'h0);
    acc(1, 1, 20'h034, 32'h20);
    acc(1, 1, 20'h030, 32'h20);
    repeat (2) @(negedge clk);
    chk({31'h0, inta_b}, 32'h1);
    rd(1, 20'h030, 32'h20);
    rd(1, 20'h044, 32'h0000_9040);
    rd(0, 20'h00158, 32'h0010_2004);
    rd(1, 20'h030, 32'h0);
    rd(1, 20'h044, 32'hFFFF_FFFF);
    acc(1, 1, 20'h044, 32'h0000_B000);
    // The store lands after the posted ack; let the buffer drain.
    repeat (4) @(posedge clk);
    rd(0, 20'h00140, 32'h0010_3004);
    chk(msg_mem_model_inst.mem[12'hC00], 32'h0000_B000);
    rd(1, 20'h100, 32'h0);
    rd(0, 20'h00034, 32'h0);
    acc(0, 1, 20'h00100, 32'h20);
    acc(0, 1, 20'h00138, 32'h0010_1004);
    rd(0, 20'h00100, 32'h0);
    // Masked post at the last entry of its region, so the head wraps.
    acc(0, 1, 20'h00104, 32'h20);
    acc(0, 1, 20'h00130, 32'h0010_1FFC);
    acc(1, 1, 20'h040, 32'h0000_C000);
    repeat (6) @(posedge clk);
    chk({31'h0, lirq}, 32'h0);
    chk(msg_mem_model_inst.mem[12'h7FF], 32'h0000_C000);
    rd(0, 20'h00130, 32'h0010_1000);
    rd(0, 20'h00100, 32'h20);
    // Mid-run reset puts outputs and pointers back to reset values.
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    chk({7'h0, inta_b, cls}, 32'h0100_0000);
    rst_b <= 1'b1;
    rd(0, 20'h00130, 32'h0);
    wrap_up();
  end
endmodule : msg_queue_unit_tb
